// ===== pkg/rso_pkg.sv
// Constants and types shared by the reset output and soft reset block.
// Operation
// RULE_01 - Supply undervoltage is a reset event
// RULE_02 - Filter, hold while present, then delay release
// RULE_03 - Power-up holds low until supply rises
// RULE_04 - Watchdog trigger failure also asserts reset
// RULE_05 - Threshold selectable, defaults to first choice
// RULE_06 - Mode value 11 returns to init mode
// RULE_07 - Soft reset restores all register defaults
// RULE_08 - Default pin select pulses reset output
// RULE_09 - Alternate pin select keeps output high
// RULE_10 - Soft reset accepted only in normal/stop
// RULE_11 - Watchdog reset: restart/fail-safe, count failures
// RULE_12 - Acts at frame end; times in oscillator cycles
package rso_pkg;

  // Clock period of the internal oscillator domain.
  localparam int CLK_PERIOD_NS = 10;

  // reset_filter_time, a least time, so it rounds up.
  localparam int FILTER_TIME_NS = 10000;
  localparam int FILTER_CYCLES =
    (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset_delay_time, a least time, so it rounds up.
  localparam int DELAY_TIME_US = 10000;
  localparam int DELAY_CYCLES =
    (DELAY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Codes of the operating-mode field.
  localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_CODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_CODE_STOP = 2'h2;
  localparam logic [1:0] MODE_CODE_SOFT_RESET = 2'h3;

  // Register defaults and the fail-count ceiling.
  localparam logic [1:0] THR_SEL_RESET = 2'h0;
  localparam logic PIN_SEL_RESET = 1'b0;
  localparam logic [1:0] WATCHDOG_FAIL_COUNT_RESET = 2'h0;
  localparam logic [1:0] WATCHDOG_FAIL_COUNT_MAX = 2'h2;

  // Device operating modes, one-hot.
  typedef enum logic [5:0] {
    MODE_INIT = 6'h01,
    MODE_NORMAL = 6'h02,
    MODE_STOP = 6'h04,
    MODE_SLEEP = 6'h08,
    MODE_RESTART = 6'h10,
    MODE_FAILSAFE = 6'h20
  } rso_mode_t;

endpackage

// ===== logic/rso_sync2.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module rso_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta_reg;

  // Only the second stage is visible; the first may be metastable.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule // rso_sync2
`default_nettype wire

// ===== logic/rso_timer.sv
// Saturating cycle counter that reports when a time has elapsed.
`timescale 1ns/10ps
`default_nettype none
module rso_timer #(
  parameter int LIMIT = 1000
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  output logic done_o
);

  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // Counting restarts from zero whenever the run condition drops.
  assign cnt_next = !run_i ? '0 : (cnt_reg == LIM) ? cnt_reg
                  : cnt_reg + W'(1);
  assign done_o = run_i && (cnt_reg == LIM);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule // rso_timer
`default_nettype wire

// ===== logic/rso_reset_ctrl.sv
// Reset output generator with soft reset and watchdog failure handling.
`timescale 1ns/10ps
`default_nettype none
module rso_reset_ctrl
  import rso_pkg::*;
#(
  parameter int FILTER_LEN = FILTER_CYCLES,
  parameter int DELAY_LEN = DELAY_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic uv_below_i,
  input wire logic watchdog_fail_count_i,
  input wire logic wd_trig_ok_i,
  input wire logic wd_failsafe_cfg_i,
  input wire logic spi_cs_n_i,
  input wire logic mode_wr_i,
  input wire logic [1:0] mode_val_i,
  input wire logic cfg_wr_i,
  input wire logic [1:0] cfg_thr_i,
  input wire logic cfg_pin_sel_i,
  output logic reset_out_n_o,
  output logic [1:0] thr_sel_o,
  output logic soft_pin_sel_o,
  output rso_mode_t mode_o,
  output logic [1:0] watchdog_fail_count_o,
  output logic regs_default_o
);

  logic uv_s;
  logic cs_s;
  logic cs_d_reg;
  logic por_hold_reg;
  logic reset_out_n_reg;
  logic mode_pend_reg;
  logic [1:0] mode_pend_val_reg;
  logic [1:0] thr_sel_reg;
  logic pin_sel_reg;
  logic [1:0] wd_cnt_reg;
  logic [1:0] wd_cnt_next;
  logic regs_default_reg;
  rso_mode_t mode_reg;
  rso_mode_t mode_next;
  logic uv_flt;
  logic dly_done;
  logic cs_rise;
  logic frame_end;
  logic soft_ok_mode;
  logic soft_exec;
  logic soft_pin_evt;
  logic hold_req;
  logic dly_run;

  // Pins from outside the clock domain are synchronised first.
  rso_sync2 #(.RST_VAL(1'b1)) u_uv_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(uv_below_i),
    .q_o(uv_s)
  );

  rso_sync2 #(.RST_VAL(1'b1)) u_cs_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(spi_cs_n_i),
    .q_o(cs_s)
  );

  // The undervoltage must persist for the filter time to count.
  rso_timer #(.LIMIT(FILTER_LEN)) u_filter (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(uv_s), // RULE_01
    .done_o(uv_flt) // RULE_02
  );

  // The release delay runs only while low and with no event present.
  rso_timer #(.LIMIT(DELAY_LEN)) u_delay (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(dly_run),
    .done_o(dly_done)
  );

  // Mode commands act only when the frame that carried them has ended.
  assign cs_rise = cs_s && !cs_d_reg;
  assign frame_end = cs_rise && mode_pend_reg; // RULE_12
  assign soft_ok_mode = (mode_reg == MODE_NORMAL)
                      || (mode_reg == MODE_STOP); // RULE_10
  assign soft_exec = frame_end && soft_ok_mode
                   && (mode_pend_val_reg == MODE_CODE_SOFT_RESET); // RULE_06
  assign soft_pin_evt = soft_exec && !pin_sel_reg; // RULE_08 RULE_09

  // Any event holds the output low; the watchdog bypasses the filter.
  assign hold_req = uv_flt || por_hold_reg || watchdog_fail_count_i // RULE_04
                  || soft_pin_evt; // RULE_02
  assign dly_run = !reset_out_n_reg && !hold_req; // RULE_02

  // Next fail count: a new failure wins over a clear in the same cycle.
  assign wd_cnt_next = watchdog_fail_count_i
                     ? ((wd_cnt_reg < WATCHDOG_FAIL_COUNT_MAX)
                        ? wd_cnt_reg + 2'h1 : wd_cnt_reg) // RULE_11
                     : (wd_trig_ok_i || soft_exec)
                     ? WATCHDOG_FAIL_COUNT_RESET : wd_cnt_reg;

  // Mode sequencing; a watchdog failure outranks any command.
  always_comb
  begin
    mode_next = mode_reg;
    if (watchdog_fail_count_i)
      mode_next = wd_failsafe_cfg_i ? MODE_FAILSAFE
                                    : MODE_RESTART; // RULE_11
    else if (soft_exec)
      mode_next = MODE_INIT; // RULE_06
    else if (frame_end)
    begin
      case (mode_reg)
        MODE_INIT:
          if (mode_pend_val_reg == MODE_CODE_NORMAL)
            mode_next = MODE_NORMAL;
        MODE_NORMAL, MODE_STOP:
          if (mode_pend_val_reg == MODE_CODE_NORMAL)
            mode_next = MODE_NORMAL;
          else if (mode_pend_val_reg == MODE_CODE_SLEEP)
            mode_next = MODE_SLEEP;
          else if (mode_pend_val_reg == MODE_CODE_STOP
                   && mode_reg == MODE_NORMAL)
            mode_next = MODE_STOP;
        default:
          mode_next = mode_reg;
      endcase
    end
    else if (mode_reg == MODE_RESTART && dly_done)
      mode_next = MODE_NORMAL;
  end

  // Reset output and power-up hold.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      por_hold_reg <= 1'b1;
      reset_out_n_reg <= 1'b0;
    end
    else
    begin
      if (!uv_s)
        por_hold_reg <= 1'b0; // RULE_03
      if (hold_req)
        reset_out_n_reg <= 1'b0; // RULE_02
      else if (dly_done)
        reset_out_n_reg <= 1'b1; // RULE_02
    end
  end

  // Pending mode command; a write in the closing cycle is kept.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_d_reg <= 1'b1;
      mode_pend_reg <= 1'b0;
      mode_pend_val_reg <= MODE_CODE_NORMAL;
    end
    else
    begin
      cs_d_reg <= cs_s;
      if (mode_wr_i)
      begin
        mode_pend_reg <= 1'b1;
        mode_pend_val_reg <= mode_val_i;
      end
      else if (cs_rise)
        mode_pend_reg <= 1'b0;
    end
  end

  // Configuration; a soft reset overrides a write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || soft_exec)
    begin
      thr_sel_reg <= THR_SEL_RESET; // RULE_05 RULE_07
      pin_sel_reg <= PIN_SEL_RESET; // RULE_07
    end
    else if (cfg_wr_i)
    begin
      thr_sel_reg <= cfg_thr_i; // RULE_05
      pin_sel_reg <= cfg_pin_sel_i;
    end
  end

  // Mode, fail count and register-default pulse.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_reg <= MODE_INIT;
      wd_cnt_reg <= WATCHDOG_FAIL_COUNT_RESET;
      regs_default_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      wd_cnt_reg <= wd_cnt_next;
      regs_default_reg <= soft_exec; // RULE_07
    end
  end

  assign reset_out_n_o = reset_out_n_reg;
  assign thr_sel_o = thr_sel_reg;
  assign soft_pin_sel_o = pin_sel_reg;
  assign mode_o = mode_reg;
  assign watchdog_fail_count_o = wd_cnt_reg;
  assign regs_default_o = regs_default_reg;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_uv_asserts: assert property ($rose(uv_flt) |=> !reset_out_n_reg) // RULE_01
    else $error("Filtered undervoltage did not pull reset low.");

  a_event_hold: assert property (hold_req |=> !reset_out_n_reg) // RULE_02
    else $error("Reset output rose while an event was present.");

  // Own count of how long the synced undervoltage has stood high, so that
  // the filter check does not lean on the timer that it is checking.
  logic [31:0] uv_age_reg;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !uv_s)
      uv_age_reg <= 32'h0;
    else if (uv_age_reg < 32'(FILTER_LEN))
      uv_age_reg <= uv_age_reg + 32'h1;
  end

  a_filter_wait: assert property (uv_flt // RULE_02
    |-> uv_age_reg >= 32'(FILTER_LEN))
    else $error("Undervoltage acted before the filter time.");

  a_delay_release: assert property ($rose(reset_out_n_reg) // RULE_02
    |-> $past(dly_done) && !$past(hold_req))
    else $error("Reset released without the full delay.");

  a_por_hold: assert property (por_hold_reg |-> !reset_out_n_reg) // RULE_03
    else $error("Reset released during power-up hold.");

  a_wd_reset: assert property (watchdog_fail_count_i |=> !reset_out_n_reg) // RULE_04
    else $error("Watchdog failure did not assert reset.");

  a_thr_default: assert property (soft_exec // RULE_05
    |=> thr_sel_reg == THR_SEL_RESET && !pin_sel_reg)
    else $error("Threshold select not restored to default.");

  a_soft_init: assert property (soft_exec && !watchdog_fail_count_i // RULE_06
    |=> mode_reg == MODE_INIT ##1 regs_default_reg == 1'b0)
    else $error("Soft reset did not return to init mode.");

  a_default_pulse: assert property (soft_exec // RULE_07
    |=> regs_default_reg && wd_cnt_reg == WATCHDOG_FAIL_COUNT_RESET
    || $past(watchdog_fail_count_i))
    else $error("Soft reset did not restore defaults.");

  a_soft_pin: assert property (soft_exec && !pin_sel_reg // RULE_08
    |=> !reset_out_n_reg)
    else $error("Soft reset did not pulse the reset output.");

  a_soft_quiet: assert property (soft_exec && pin_sel_reg // RULE_09
    && reset_out_n_reg && !uv_flt && !watchdog_fail_count_i
    |=> reset_out_n_reg)
    else $error("Soft reset pulsed reset with pin select set.");

  a_soft_gate: assert property (soft_exec // RULE_10
    |-> mode_reg == MODE_NORMAL || mode_reg == MODE_STOP)
    else $error("Soft reset accepted outside normal or stop.");

  a_soft_ignored: assert property (frame_end && !soft_ok_mode // RULE_10
    && mode_pend_val_reg == MODE_CODE_SOFT_RESET && !watchdog_fail_count_i
    |=> !regs_default_reg && mode_reg == $past(mode_reg))
    else $error("Soft reset acted outside normal or stop.");

  a_sleep_keep: assert property (mode_reg == MODE_SLEEP // RULE_10
    && !watchdog_fail_count_i |=> mode_reg == MODE_SLEEP)
    else $error("Sleep mode left without a reset.");

  a_wd_mode: assert property (watchdog_fail_count_i |=> mode_reg == // RULE_11
    ($past(wd_failsafe_cfg_i) ? MODE_FAILSAFE : MODE_RESTART))
    else $error("Watchdog failure entered the wrong mode.");

  a_wd_count: assert property (watchdog_fail_count_i // RULE_11
    && wd_cnt_reg < WATCHDOG_FAIL_COUNT_MAX |=> wd_cnt_reg == $past(wd_cnt_reg) + 2'h1)
    else $error("Watchdog failure count did not advance.");

  a_wd_saturate: assert property (watchdog_fail_count_i // RULE_11
    && wd_cnt_reg == WATCHDOG_FAIL_COUNT_MAX |=> wd_cnt_reg == WATCHDOG_FAIL_COUNT_MAX)
    else $error("Watchdog failure count passed its ceiling.");

  a_frame_end: assert property (soft_exec // RULE_12
    |-> cs_s && !$past(cs_s) && mode_pend_reg)
    else $error("Soft reset acted inside a frame.");

endmodule // rso_reset_ctrl
`default_nettype wire

// ===== dv/rso_mcu_model.sv
// Microcontroller model that frames mode writes on the serial link.
`timescale 1ns/10ps
`default_nettype none
module rso_mcu_model (
  input wire logic clk_i,
  output logic spi_cs_n_o,
  output logic mode_wr_o,
  output logic [1:0] mode_val_o
);
  // The link idles deselected.
  initial
  begin
    spi_cs_n_o = 1'b1;
    mode_wr_o = 1'b0;
    mode_val_o = 2'h0;
  end

  // One frame with one mode write. The value is scrambled after the strobe
  // so that a stale value is never mistaken for a live one.
  task automatic send_mode(input logic [1:0] v);
    @(posedge clk_i);
    spi_cs_n_o <= 1'b0;
    @(posedge clk_i);
    mode_wr_o <= 1'b1;
    mode_val_o <= v;
    @(posedge clk_i);
    mode_wr_o <= 1'b0;
    mode_val_o <= ~v;
    repeat (2) @(posedge clk_i);
    spi_cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // rso_mcu_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking testbench for the reset output and soft reset block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rso_pkg::*;
  localparam int FL = 4;
  localparam int DL = 8;
  logic clk_i, sys_rst_i, uv, watchdog_fail_count, trig_ok, fs_cfg, cfg_wr, pin_sel;
  logic cs_n, mode_wr, rst_n, soft_pin, regs_def;
  logic [1:0] mode_val, cfg_thr, thr_sel, wd_cnt, r;
  rso_mode_t mode;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int defs = 0;
  int lows = 0;
  int n, k, i;

  rso_reset_ctrl #(.FILTER_LEN(FL), .DELAY_LEN(DL)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .uv_below_i(uv),
    .watchdog_fail_count_i(watchdog_fail_count), .wd_trig_ok_i(trig_ok), .wd_failsafe_cfg_i(fs_cfg),
    .spi_cs_n_i(cs_n), .mode_wr_i(mode_wr), .mode_val_i(mode_val),
    .cfg_wr_i(cfg_wr), .cfg_thr_i(cfg_thr), .cfg_pin_sel_i(pin_sel),
    .reset_out_n_o(rst_n), .thr_sel_o(thr_sel), .soft_pin_sel_o(soft_pin),
    .mode_o(mode), .watchdog_fail_count_o(wd_cnt), .regs_default_o(regs_def)
  );

  rso_mcu_model i_mcu (
    .clk_i(clk_i), .spi_cs_n_o(cs_n), .mode_wr_o(mode_wr),
    .mode_val_o(mode_val)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Cycle count, pulse tallies and the hang guard.
  always @(posedge clk_i)
  begin
    cyc++;
    if (regs_def === 1'b1) defs++;
    if (rst_n === 1'b0) lows++;
    if (cyc == 4000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi,
                         input string m);
    comparisons++;
    if (v < lo || v > hi)
    begin
      fails++;
      $display("wrong value at %0t: %s %0d", $time, m, v);
    end
  endtask

  // Counts edges until the reset output reaches a level, up to a bound.
  task automatic wait_lvl(input logic lvl, input int mx);
    n = 0;
    while (rst_n !== lvl && n < mx)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask

  task automatic wd_pulse();
    @(posedge clk_i);
    watchdog_fail_count <= 1'b1;
    @(posedge clk_i);
    watchdog_fail_count <= 1'b0;
    #1;
  endtask

  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence; the filter and delay are shortened by parameter.
  initial
  begin
    {sys_rst_i, uv, watchdog_fail_count, trig_ok, fs_cfg} = 5'h10;
    {cfg_wr, cfg_thr, pin_sel} = 4'h0;
    r = 2'($urandom(67));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(rst_n, 0, "por");
    chk(thr_sel, 0, "thr");
    wait_lvl(1'b1, 300);
    chk_rng(n, DL - 1, DL + 3, "por rel");
    i_mcu.send_mode(MODE_CODE_NORMAL);
    // A dip shorter than the filter must leave the output alone.
    @(posedge clk_i);
    uv <= 1'b1;
    repeat (2) @(posedge clk_i);
    uv <= 1'b0;
    wait_lvl(1'b0, 20);
    chk_rng(n, 20, 20, "glitch");
    k = 6 + $urandom % 15;
    @(posedge clk_i);
    uv <= 1'b1;
    wait_lvl(1'b0, 300);
    chk_rng(n, FL + 1, FL + 4, "uv fall");
    repeat (k) @(posedge clk_i);
    uv <= 1'b0;
    wait_lvl(1'b1, 300);
    chk_rng(n, DL + 1, DL + 3, "uv rel");
    // Three failures in a row: the count saturates at two.
    for (i = 1; i < 4; i++)
    begin
      wd_pulse();
      chk(rst_n, 0, "wd rst");
      chk(mode, MODE_RESTART, "restart");
      chk(wd_cnt, (i > 2) ? 2 : i, "wd cnt");
      wait_lvl(1'b1, 300);
      chk_rng(n, DL, DL + 1, "wd rel");
      chk(mode, MODE_NORMAL, "back");
    end
    @(posedge clk_i);
    trig_ok <= 1'b1;
    @(posedge clk_i);
    trig_ok <= 1'b0;
    #1;
    chk(wd_cnt, 0, "cnt clr");
    @(posedge clk_i);
    cfg_wr <= 1'b1;
    cfg_thr <= (r == 2'h0) ? 2'h3 : r;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    #1;
    chk(thr_sel, (r == 2'h0) ? 3 : r, "thr set");
    i_mcu.send_mode(MODE_CODE_SOFT_RESET);
    #1;
    chk(defs, 1, "defaults");
    chk(mode, MODE_INIT, "soft init");
    chk(thr_sel, 0, "thr def");
    chk(rst_n, 0, "soft rst");
    wait_lvl(1'b1, 300);
    chk_rng(n, DL - 2, DL - 2, "soft rel");
    i_mcu.send_mode(MODE_CODE_NORMAL);
    i_mcu.send_mode(MODE_CODE_STOP);
    @(posedge clk_i);
    cfg_wr <= 1'b1;
    pin_sel <= 1'b1;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    #1;
    chk(soft_pin, 1, "pin set");
    k = lows;
    i_mcu.send_mode(MODE_CODE_SOFT_RESET);
    #1;
    chk(lows - k, 0, "no pulse");
    chk({defs[1:0], soft_pin}, 8'h4, "pin def");
    chk(mode, MODE_INIT, "stop soft");
    // Soft reset from init mode must be ignored.
    i_mcu.send_mode(MODE_CODE_SOFT_RESET);
    #1;
    chk(defs, 2, "ignored");
    i_mcu.send_mode(MODE_CODE_NORMAL);
    @(posedge clk_i);
    fs_cfg <= 1'b1;
    wd_pulse();
    chk(mode, MODE_FAILSAFE, "failsafe");
    // A second power-on reset mid-run, then sleep, where soft reset is
    // refused.
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(rst_n, 0, "por 2");
    chk(wd_cnt, 0, "cnt por");
    wait_lvl(1'b1, 300);
    chk_rng(n, DL + 3, DL + 3, "por rel 2");
    i_mcu.send_mode(MODE_CODE_NORMAL);
    i_mcu.send_mode(MODE_CODE_SLEEP);
    #1;
    chk(mode, MODE_SLEEP, "sleep");
    k = lows;
    i_mcu.send_mode(MODE_CODE_SOFT_RESET);
    #1;
    chk(mode, MODE_SLEEP, "sleep soft");
    chk(defs, 2, "sleep ign");
    chk(lows - k, 0, "sleep pin");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
